// File: rtl/cmd_pkg.sv
// Purpose: constants for the sensor unit command handshake
// Assumes: 16-bit output word from the controller, 16-bit input word back
// Notes: register map is served over apb, one aligned word per register
// Behaviour
// - idle or no command shows live data
// - teach/set echo valid code, else error
// - read commands return stored setting (CC00 live data) or error
// - set parameter echoed; only hysteresis is range-checked, out of range gives error
// - signed read alternates sign and value half-second
// - command start/end only on word change
// - mode groups at C000/C100, C200/C300
// - scaling points C4**, C5*0, C6*0
// - thresholds C7**, C8*0, C9*0
// - hysteresis CA00/CB00, CC00 present value
// - mode group one kept in nonvolatile storage
// - mode settings may refuse inapplicable commands
// - E000 unknown code, E001 bad parameter
// - E002 teach failed, E003 mode forbids
// - C000 through CFFF always a command (code decodes them only in idle; after a set code such a word is the parameter)
package cmd_pkg;
	localparam logic [3:0]  CMD_NIBBLE   = 4'h_C;
	localparam logic [15:0] IDLE_WORD    = 16'h_0000;
	localparam logic [3:0]  OP_MODEA_SET = 4'h_0;
	localparam logic [3:0]  OP_MODEA_RD  = 4'h_1;
	localparam logic [3:0]  OP_MODEB_SET = 4'h_2;
	localparam logic [3:0]  OP_MODEB_RD  = 4'h_3;
	localparam logic [3:0]  OP_SCL_SET   = 4'h_4;
	localparam logic [3:0]  OP_SCL_TEACH = 4'h_5;
	localparam logic [3:0]  OP_SCL_RD    = 4'h_6;
	localparam logic [3:0]  OP_THR_SET   = 4'h_7;
	localparam logic [3:0]  OP_THR_TEACH = 4'h_8;
	localparam logic [3:0]  OP_THR_RD    = 4'h_9;
	localparam logic [3:0]  OP_HYS_SET   = 4'h_A;
	localparam logic [3:0]  OP_HYS_RD    = 4'h_B;
	localparam logic [3:0]  OP_PV_RD     = 4'h_C;
	localparam logic [15:0] ERR_CODE     = 16'h_E000;
	localparam logic [15:0] ERR_PARAM    = 16'h_E001;
	localparam logic [15:0] ERR_TEACH    = 16'h_E002;
	localparam logic [15:0] ERR_MODE     = 16'h_E003;
	localparam logic [15:0] SIGN_POS     = 16'h_A000;
	localparam logic [15:0] SIGN_NEG     = 16'h_A00F;
	localparam logic [3:0]  NUM_POINTS   = 4'h_4;
	localparam logic [15:0] HYS_MIN      = 16'h_0001;
	localparam logic [15:0] HYS_MAX      = 16'h_0999;
	localparam logic [15:0] HYS_RESET    = 16'h_0001;
	localparam logic [15:0] MODE_RESET   = 16'h_0000;
	// timing hold field of mode group one: zero means normal
	localparam int          HOLD_LSB     = 4;
	localparam logic [3:0]  HOLD_NORMAL  = 4'h_0;
	// signed read alternation interval
	localparam int          ALT_MS       = 500;
	localparam int          CLK_KHZ      = 50000;
	localparam int          ALT_CYCLES   = ALT_MS * CLK_KHZ;
	// apb register offsets
	localparam logic [7:0]  A_OUT_WORD   = 8'h_00;
	localparam logic [7:0]  A_IN_WORD    = 8'h_04;
	localparam logic [7:0]  A_LIVE       = 8'h_08;
	localparam logic [7:0]  A_STATUS     = 8'h_0C;
	localparam logic [7:0]  A_MASK       = 8'h_10;
	localparam logic [7:0]  A_TEACH_OK   = 8'h_14;
	// status bits: command done, error answered
	localparam int          ST_DONE      = 0;
	localparam int          ST_ERR       = 1;
	typedef enum logic [3:0] {
		S_IDLE  = 4'b0001,
		S_RESP  = 4'b0010,
		S_PARAM = 4'b0100,
		S_SIGN  = 4'b1000
	} state_t;
endpackage

// File: rtl/sensor_cmd.sv
// Purpose: command interpreter answering through the input word
// Assumes: apb master holds requests; live data supplied as an input
// Notes: nonvolatile storage is modelled as retained registers
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module sensor_cmd #(
	parameter int ALT_COUNT = cmd_pkg::ALT_CYCLES // half-second in cycles
) (
	input  wire logic        clock,      // 50 MHz clock
	input  wire logic        rst_n,      // synchronous reset, active low
	input  wire logic        clk_en,     // freezes all state when low
	input  wire logic [15:0] live_data,  // scaled data or comparison flags
	input  wire logic        psel,       // apb select
	input  wire logic        penable,    // apb access phase
	input  wire logic        pwrite,     // apb direction
	input  wire logic [7:0]  paddr,      // apb byte address
	input  wire logic [31:0] pwdata,     // apb write data
	output logic      [31:0] prdata,     // apb read data
	output logic             pready,     // apb ready
	output logic             pslverr,    // apb error on unmapped address
	output logic             irq         // level interrupt
);
	logic [15:0] out_word_reg;
	logic [15:0] in_word_reg;
	logic [15:0] mode_a_reg;
	logic [15:0] mode_b_reg;
	logic [15:0] hys_reg;
	logic [15:0] scl_reg [4];
	logic [15:0] thr_reg [4];
	logic [1:0]  status_reg;
	logic [1:0]  mask_reg;
	logic        teach_ok_reg;
	cmd_pkg::state_t state_reg;
	logic [15:0] cmd_reg;
	logic        show_val_reg;
	logic [31:0] alt_cnt_reg;
	logic [15:0] sv_val_reg;

	logic        wr_en;
	logic        rd_en;
	logic [15:0] new_word;
	logic        word_change;
	logic        is_cmd;
	logic [3:0]  op;
	logic [3:0]  pt;
	logic        hold_normal;
	logic        ev_done;
	logic        ev_err;

	// apb access strobes, answer in the access cycle
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && penable && !pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !(paddr == cmd_pkg::A_OUT_WORD
		|| paddr == cmd_pkg::A_IN_WORD || paddr == cmd_pkg::A_LIVE
		|| paddr == cmd_pkg::A_STATUS || paddr == cmd_pkg::A_MASK
		|| paddr == cmd_pkg::A_TEACH_OK);

	// output word written by the controller
	assign new_word    = pwdata[15:0];
	assign word_change = wr_en && paddr == cmd_pkg::A_OUT_WORD
		&& new_word != out_word_reg;
	assign is_cmd      = new_word[15:12] == cmd_pkg::CMD_NIBBLE;
	assign op          = new_word[11:8];
	assign pt          = new_word[7:4];
	assign hold_normal = mode_a_reg[cmd_pkg::HOLD_LSB +: 4]
		== cmd_pkg::HOLD_NORMAL;
	assign ev_done = word_change && state_reg != cmd_pkg::S_IDLE;
	assign ev_err  = word_change && in_word_reg[15:12] == 4'h_E
		&& state_reg != cmd_pkg::S_IDLE;

	// output word store
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			out_word_reg <= cmd_pkg::IDLE_WORD;
		end else if (clk_en && word_change) begin
			out_word_reg <= new_word;
		end
	end

	// software-writable teach permit and mask
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mask_reg     <= 2'b00;
			teach_ok_reg <= 1'b1;
		end else if (clk_en && wr_en) begin
			if (paddr == cmd_pkg::A_MASK) begin
				mask_reg <= pwdata[1:0];
			end
			if (paddr == cmd_pkg::A_TEACH_OK) begin
				teach_ok_reg <= pwdata[0];
			end
		end
	end

	// sticky status, cleared by read; a new event wins
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			status_reg <= 2'b00;
		end else if (clk_en) begin
			if (rd_en && paddr == cmd_pkg::A_STATUS) begin
				status_reg <= {ev_err, ev_done};
			end else begin
				status_reg <= status_reg | {ev_err, ev_done};
			end
		end
	end
	assign irq = |(status_reg & mask_reg);

	// apb read mux
	always_comb begin
		prdata = 32'h_0000_0000;
		unique case (paddr)
			cmd_pkg::A_OUT_WORD: prdata = {16'h_0000, out_word_reg};
			cmd_pkg::A_IN_WORD:  prdata = {16'h_0000, in_word_reg};
			cmd_pkg::A_LIVE:     prdata = {16'h_0000, live_data};
			cmd_pkg::A_STATUS:   prdata = {30'h_0, status_reg};
			cmd_pkg::A_MASK:     prdata = {30'h_0, mask_reg};
			cmd_pkg::A_TEACH_OK: prdata = {31'h_0, teach_ok_reg};
			default:             prdata = 32'h_0000_0000;
		endcase
	end

	// stored settings, retained across the controller's commands
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mode_a_reg <= cmd_pkg::MODE_RESET;
			mode_b_reg <= cmd_pkg::MODE_RESET;
			hys_reg    <= cmd_pkg::HYS_RESET;
			for (int i = 0; i < 4; i++) begin
				scl_reg[i] <= cmd_pkg::IDLE_WORD;
				thr_reg[i] <= cmd_pkg::IDLE_WORD;
			end
		end else if (clk_en && word_change
			&& state_reg == cmd_pkg::S_PARAM) begin
			unique case (cmd_reg[11:8])
				cmd_pkg::OP_MODEA_SET: mode_a_reg <= new_word;
				cmd_pkg::OP_MODEB_SET: mode_b_reg <= new_word;
				cmd_pkg::OP_HYS_SET: begin
					if (new_word >= cmd_pkg::HYS_MIN
						&& new_word <= cmd_pkg::HYS_MAX) begin
						hys_reg <= new_word;
					end
				end
				cmd_pkg::OP_SCL_SET: scl_reg[cmd_reg[5:4]] <= new_word;
				cmd_pkg::OP_THR_SET: thr_reg[cmd_reg[5:4]] <= new_word;
				default: ;
			endcase
		end else if (clk_en && word_change && is_cmd && hold_normal
			&& teach_ok_reg && state_reg == cmd_pkg::S_IDLE
			&& pt < cmd_pkg::NUM_POINTS && new_word[3:0] == 4'h_0) begin
			// teach captures present data
			if (op == cmd_pkg::OP_SCL_TEACH) begin
				scl_reg[pt[1:0]] <= live_data;
			end else if (op == cmd_pkg::OP_THR_TEACH) begin
				thr_reg[pt[1:0]] <= live_data;
			end
		end
	end

	// command sequencer and input word
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg    <= cmd_pkg::S_IDLE;
			cmd_reg      <= cmd_pkg::IDLE_WORD;
			in_word_reg  <= cmd_pkg::IDLE_WORD;
			show_val_reg <= 1'b0;
			alt_cnt_reg  <= 32'h_0000_0000;
			sv_val_reg   <= cmd_pkg::IDLE_WORD;
		end else if (clk_en) begin
			unique case (state_reg)
				cmd_pkg::S_IDLE: begin
					in_word_reg <= live_data;
					if (word_change && is_cmd) begin
						cmd_reg     <= new_word;
						state_reg   <= cmd_pkg::S_RESP;
						in_word_reg <= cmd_pkg::ERR_CODE;
						unique case (op)
							cmd_pkg::OP_MODEA_SET, cmd_pkg::OP_MODEB_SET,
							cmd_pkg::OP_HYS_SET: begin
								if (new_word[7:0] == 8'h_00) begin
									in_word_reg <= new_word;
									state_reg   <= cmd_pkg::S_PARAM;
								end
							end
							cmd_pkg::OP_SCL_SET, cmd_pkg::OP_THR_SET: begin
								if (pt < cmd_pkg::NUM_POINTS) begin
									in_word_reg <= new_word;
									state_reg   <= cmd_pkg::S_PARAM;
								end
							end
							cmd_pkg::OP_SCL_TEACH,
							cmd_pkg::OP_THR_TEACH: begin
								if (pt >= cmd_pkg::NUM_POINTS
									|| new_word[3:0] != 4'h_0) begin
									in_word_reg <= cmd_pkg::ERR_CODE;
								end else if (!hold_normal) begin
									in_word_reg <= cmd_pkg::ERR_MODE;
								end else if (!teach_ok_reg) begin
									in_word_reg <= cmd_pkg::ERR_TEACH;
								end else begin
									in_word_reg <= new_word;
								end
							end
							cmd_pkg::OP_MODEA_RD: begin
								if (new_word[7:0] == 8'h_00) begin
									in_word_reg <= mode_a_reg;
								end
							end
							cmd_pkg::OP_MODEB_RD: begin
								if (new_word[7:0] == 8'h_00) begin
									in_word_reg <= mode_b_reg;
								end
							end
							cmd_pkg::OP_HYS_RD: begin
								if (new_word[7:0] == 8'h_00) begin
									in_word_reg <= hys_reg;
								end
							end
							cmd_pkg::OP_SCL_RD, cmd_pkg::OP_THR_RD: begin
								if (pt < cmd_pkg::NUM_POINTS
									&& new_word[3:0] == 4'h_0) begin
									sv_val_reg <= (op == cmd_pkg::OP_SCL_RD)
										? scl_reg[pt[1:0]]
										: thr_reg[pt[1:0]];
									in_word_reg <= ((op == cmd_pkg::OP_SCL_RD
										? scl_reg[pt[1:0]]
										: thr_reg[pt[1:0]]) & 16'h_8000)
										!= 16'h_0000 ? cmd_pkg::SIGN_NEG
										: cmd_pkg::SIGN_POS;
									state_reg    <= cmd_pkg::S_SIGN;
									show_val_reg <= 1'b0;
									alt_cnt_reg  <= 32'h_0000_0000;
								end
							end
							cmd_pkg::OP_PV_RD: begin
								if (new_word[7:0] == 8'h_00) begin
									sv_val_reg  <= live_data;
									in_word_reg <= live_data[15]
										? cmd_pkg::SIGN_NEG
										: cmd_pkg::SIGN_POS;
									state_reg    <= cmd_pkg::S_SIGN;
									show_val_reg <= 1'b0;
									alt_cnt_reg  <= 32'h_0000_0000;
								end
							end
							default: ;
						endcase
					end
				end
				cmd_pkg::S_PARAM: begin
					// parameter word after the code echo
					if (word_change) begin
						state_reg   <= cmd_pkg::S_RESP;
						in_word_reg <= new_word;
						if (cmd_reg[11:8] == cmd_pkg::OP_HYS_SET
							&& (new_word < cmd_pkg::HYS_MIN
							|| new_word > cmd_pkg::HYS_MAX)) begin
							in_word_reg <= cmd_pkg::ERR_PARAM;
						end
					end
				end
				cmd_pkg::S_RESP: begin
					// answer holds until the word changes
					if (word_change) begin
						state_reg   <= cmd_pkg::S_IDLE;
						in_word_reg <= live_data;
					end
				end
				cmd_pkg::S_SIGN: begin
					if (word_change) begin
						state_reg   <= cmd_pkg::S_IDLE;
						in_word_reg <= live_data;
					end else if (alt_cnt_reg == 32'(ALT_COUNT - 1)) begin
						alt_cnt_reg  <= 32'h_0000_0000;
						show_val_reg <= !show_val_reg;
						in_word_reg  <= show_val_reg
							? (sv_val_reg[15] ? cmd_pkg::SIGN_NEG
							: cmd_pkg::SIGN_POS)
							: sv_val_reg;
					end else begin
						alt_cnt_reg <= alt_cnt_reg + 32'h_0000_0001;
					end
				end
				default: state_reg <= cmd_pkg::S_IDLE;
			endcase
		end
	end

	// a mode or hysteresis read answer, echo or error stays put until the next change
	property p_hold;
		@(posedge clock) disable iff (!rst_n)
		(state_reg == cmd_pkg::S_RESP && !word_change && clk_en)
			|=> $stable(in_word_reg);
	endproperty
	a_resp_hold: assert property (p_hold)
		else $error("response changed without a new output word");

	a_idle_live: assert property (
		@(posedge clock) disable iff (!rst_n)
		state_reg == cmd_pkg::S_IDLE && clk_en && !word_change
		|=> in_word_reg == $past(live_data))
		else $error("idle input word is not live data");

	a_same_word: assert property (
		@(posedge clock) disable iff (!rst_n)
		clk_en && wr_en && paddr == cmd_pkg::A_OUT_WORD
		&& pwdata[15:0] == out_word_reg && state_reg != cmd_pkg::S_IDLE
		|=> state_reg != cmd_pkg::S_IDLE)
		else $error("unchanged output word ended a command");

	sequence s_bad_hys;
		state_reg == cmd_pkg::S_PARAM && word_change && clk_en
		&& cmd_reg[11:8] == cmd_pkg::OP_HYS_SET
		&& new_word > cmd_pkg::HYS_MAX;
	endsequence
	a_param_err: assert property (
		@(posedge clock) disable iff (!rst_n)
		s_bad_hys |=> in_word_reg == cmd_pkg::ERR_PARAM)
		else $error("bad parameter not answered with parameter error");

	a_unknown: assert property (
		@(posedge clock) disable iff (!rst_n)
		state_reg == cmd_pkg::S_IDLE && word_change && clk_en && is_cmd
		&& op > cmd_pkg::OP_PV_RD
		|=> in_word_reg == cmd_pkg::ERR_CODE)
		else $error("unknown code not answered with code error");

	a_set_echo: assert property (
		@(posedge clock) disable iff (!rst_n)
		state_reg == cmd_pkg::S_IDLE && word_change && clk_en
		&& new_word == 16'h_C200
		|=> in_word_reg == 16'h_C200 && state_reg == cmd_pkg::S_PARAM)
		else $error("set code not echoed");

	a_teach_mode: assert property (
		@(posedge clock) disable iff (!rst_n)
		state_reg == cmd_pkg::S_IDLE && word_change && clk_en && is_cmd
		&& op == cmd_pkg::OP_SCL_TEACH && new_word[7:0] == 8'h_00
		&& !hold_normal |=> in_word_reg == cmd_pkg::ERR_MODE)
		else $error("teach allowed against mode setting");

	a_mode_read: assert property (
		@(posedge clock) disable iff (!rst_n)
		state_reg == cmd_pkg::S_IDLE && word_change && clk_en
		&& new_word == 16'h_C100
		|=> in_word_reg == $past(mode_a_reg))
		else $error("mode read returned wrong value");

	a_sign_first: assert property (
		@(posedge clock) disable iff (!rst_n)
		$rose(state_reg == cmd_pkg::S_SIGN)
		|-> in_word_reg == cmd_pkg::SIGN_POS
		|| in_word_reg == cmd_pkg::SIGN_NEG)
		else $error("signed read did not start with sign word");
endmodule

// File: tb/ctrl_model.sv
// Purpose: controller model on the apb side of the unit
// Assumes: slave answers by pready, wait states allowed
// Notes: the testbench calls the tasks hierarchically
`timescale 1ns/1ps
module ctrl_model (
	input  wire logic        clock,   // bench clock
	output logic             psel,    // apb select
	output logic             penable, // apb access phase
	output logic             pwrite,  // apb direction
	output logic      [7:0]  paddr,   // apb byte address
	output logic      [31:0] pwdata,  // apb write data
	input  wire logic [31:0] prdata,  // apb read data
	input  wire logic        pready,  // apb ready
	input  wire logic        pslverr  // apb error
);
	// bus idle from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h_00;
		pwdata = 32'h_0000_0000;
	end
	// one transfer, held until pready is sampled high
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// new output word, then the answer is fetched before moving on
	task automatic command(input logic [15:0] w, output logic [15:0] r);
		logic [31:0] q;
		logic        e;
		xfer(1'b1, 8'h_00, {16'h_0000, w}, q, e);
		xfer(1'b0, 8'h_04, 32'h_0000_0000, q, e);
		r = q[15:0];
	endtask
endmodule

// File: tb/testbench.sv
// Purpose: self-checking bench for the command interpreter
// Assumes: short alternation count, zero wait apb slave
// Notes: every scenario judges its own answers
`timescale 1ns/1ps
module testbench;
	localparam int ALT = 8;
	logic        clock;
	logic        rst_n;
	logic        clk_en;
	logic [15:0] live_data;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic [31:0] q;
	logic        e;
	logic [15:0] r;
	int          bad_count;
	int          checked;

	// free running 50 MHz clock
	always #10 clock = ~clock;

	ctrl_model ctrl_u (
		.clock   (clock),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr)
	);
	sensor_cmd #(.ALT_COUNT(ALT)) dut_u (
		.clock     (clock),
		.rst_n     (rst_n),
		.clk_en    (clk_en),
		.live_data (live_data),
		.psel      (psel),
		.penable   (penable),
		.pwrite    (pwrite),
		.paddr     (paddr),
		.pwdata    (pwdata),
		.prdata    (prdata),
		.pready    (pready),
		.pslverr   (pslverr),
		.irq       (irq)
	);
	// compare one value and count it
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// send a word and compare the answer in the input word
	task automatic cc(input logic [15:0] w, input logic [15:0] exp);
		ctrl_u.command(w, r);
		check({16'h_0000, r}, {16'h_0000, exp});
	endtask
	// register write through the model
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ctrl_u.xfer(1'b1, a, d, q, e);
	endtask
	// print the counts and the verdict, then stop
	task automatic wrap_up;
		$display("checked %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// live data in idle, plain values are not commands
	task automatic t_idle;
		@(posedge clock);
		live_data <= 16'h_0123;
		cc(16'h_1234, 16'h_0123);
		ctrl_u.xfer(1'b0, 8'h_08, 32'h_0, q, e);
		check(q, 32'h_0000_0123);
		ctrl_u.xfer(1'b0, 8'h_20, 32'h_0, q, e);
		check(q, 32'h_0000_0000);
		check({31'h_0, e}, 32'h_0000_0001);
		cc(16'h_0000, 16'h_0123);
		$display("test idle done");
	endtask
	// set commands, zero parameter end, mode reads
	task automatic t_set;
		cc(16'h_C200, 16'h_C200);
		cc(16'h_0042, 16'h_0042);
		cc(16'h_0000, 16'h_0123);
		cc(16'h_C300, 16'h_0042);
		cc(16'h_0000, 16'h_0123);
		cc(16'h_C000, 16'h_C000);
		cc(16'h_0000, 16'h_0000);
		cc(16'h_0000, 16'h_0000);
		cc(16'h_1111, 16'h_0123);
		cc(16'h_CA00, 16'h_CA00);
		cc(16'h_1000, 16'h_E001);
		cc(16'h_0000, 16'h_0123);
		cc(16'h_CA00, 16'h_CA00);
		cc(16'h_0999, 16'h_0999);
		cc(16'h_0000, 16'h_0123);
		cc(16'h_CB00, 16'h_0999);
		cc(16'h_0000, 16'h_0123);
		for (int i = 13; i < 16; i++) begin
			cc({4'h_C, i[3:0], 8'h_00}, 16'h_E000);
			cc(16'h_0000, 16'h_0123);
		end
		cc(16'h_C110, 16'h_E000);
		cc(16'h_0000, 16'h_0123);
		$display("test set done");
	endtask
	// teach, signed read alternation, refused teach
	task automatic t_teach;
		@(posedge clock);
		live_data <= 16'h_0100;
		cc(16'h_C810, 16'h_C810);
		cc(16'h_0000, 16'h_0100);
		cc(16'h_C910, 16'h_A000);
		repeat (ALT) @(posedge clock);
		ctrl_u.xfer(1'b0, 8'h_04, 32'h_0, q, e);
		check(q, 32'h_0000_0100);
		repeat (ALT / 2) @(posedge clock);
		ctrl_u.xfer(1'b0, 8'h_04, 32'h_0, q, e);
		check(q, 32'h_0000_A000);
		cc(16'h_0000, 16'h_0100);
		cc(16'h_C420, 16'h_C420);
		cc(16'h_8077, 16'h_8077);
		cc(16'h_0000, 16'h_0100);
		cc(16'h_C620, 16'h_A00F);
		cc(16'h_0000, 16'h_0100);
		cc(16'h_C730, 16'h_C730);
		cc(16'h_0055, 16'h_0055);
		cc(16'h_0000, 16'h_0100);
		cc(16'h_C930, 16'h_A000);
		cc(16'h_0000, 16'h_0100);
		cc(16'h_CC00, 16'h_A000);
		cc(16'h_0000, 16'h_0100);
		wr(8'h_14, 32'h_0);
		cc(16'h_C800, 16'h_E002);
		cc(16'h_0000, 16'h_0100);
		wr(8'h_14, 32'h_1);
		cc(16'h_C000, 16'h_C000);
		cc(16'h_0010, 16'h_0010);
		cc(16'h_0000, 16'h_0100);
		cc(16'h_C100, 16'h_0010);
		cc(16'h_0000, 16'h_0100);
		cc(16'h_C500, 16'h_E003);
		cc(16'h_0000, 16'h_0100);
		$display("test teach done");
	endtask
	// status, mask and level interrupt
	task automatic t_irq;
		ctrl_u.xfer(1'b0, 8'h_0C, 32'h_0, q, e);
		cc(16'h_CD00, 16'h_E000);
		cc(16'h_0000, 16'h_0100);
		check({31'h_0, irq}, 32'h_0);
		wr(8'h_10, 32'h_3);
		@(posedge clock);
		check({31'h_0, irq}, 32'h_1);
		ctrl_u.xfer(1'b0, 8'h_0C, 32'h_0, q, e);
		check(q & 32'h_3, 32'h_3);
		@(posedge clock);
		check({31'h_0, irq}, 32'h_0);
		$display("test irq done");
	endtask
	// a low clock enable drops the write and holds the output word
	task automatic t_freeze;
		@(posedge clock);
		clk_en <= 1'b0;
		ctrl_u.xfer(1'b1, 8'h_00, 32'h_0000_C100, q, e);
		@(posedge clock);
		clk_en <= 1'b1;
		ctrl_u.xfer(1'b0, 8'h_00, 32'h_0, q, e);
		check(q, 32'h_0000_0000);
		cc(16'h_0000, 16'h_0100);
		$display("test freeze done");
	endtask
	// reset, then the scenarios in turn
	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		clk_en = 1'b1;
		live_data = 16'h_0000;
		bad_count = 0;
		checked = 0;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		t_idle();
		t_set();
		t_teach();
		t_irq();
		t_freeze();
		wrap_up();
	end
	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clock);
		bad_count++;
		wrap_up();
	end
endmodule
